// file: ismh_pkg.sv
// Constants, register map and state encoding of the two-wire master engine
package ismh_pkg;

    // =====================================================================
    // Register offsets (byte addresses on the bus)
    localparam logic [7:0] CTRL_OFS     = 8'h00;
    localparam logic [7:0] STAT_OFS     = 8'h04;
    localparam logic [7:0] DATA_OFS     = 8'h08;
    localparam logic [7:0] IRQ_STAT_OFS = 8'h0C;
    localparam logic [7:0] IRQ_MASK_OFS = 8'h10;

    // =====================================================================
    // Control register fields
    localparam int unsigned CTRL_FLAG_BIT = 7;
    localparam int unsigned CTRL_STA_BIT  = 5;
    localparam int unsigned CTRL_STO_BIT  = 4;
    localparam int unsigned CTRL_WC_BIT   = 3;
    localparam int unsigned CTRL_EN_BIT   = 2;

    // =====================================================================
    // Status register fields and codes (low three bits masked)
    localparam int unsigned STAT_CODE_LSB = 3;
    localparam int unsigned STAT_PRE_W    = 2;
    localparam logic [7:0] ST_START   = 8'h08;
    localparam logic [7:0] ST_RSTART  = 8'h10;
    localparam logic [7:0] ST_AACK    = 8'h18;
    localparam logic [7:0] ST_ANACK   = 8'h20;
    localparam logic [7:0] ST_DACK    = 8'h28;
    localparam logic [7:0] ST_DNACK   = 8'h30;
    localparam logic [7:0] ST_NOINFO  = 8'hF8;

    // =====================================================================
    // Interrupt status bits
    localparam int unsigned IRQ_W        = 3;
    localparam int unsigned IRQ_DONE_BIT = 0;
    localparam int unsigned IRQ_WC_BIT   = 1;
    localparam int unsigned IRQ_NACK_BIT = 2;

    // =====================================================================
    // Reset values
    localparam logic [7:0]       DATA_RST = 8'hFF;
    localparam logic [1:0]       PRE_RST  = 2'h0;
    localparam logic [IRQ_W-1:0] MASK_RST = 3'h0;

    // =====================================================================
    // Timing: one quarter of a bus bit, least time, rounded up
    localparam int unsigned CLK_NS     = 40;
    localparam int unsigned SCL_QTR_NS = 2500;
    localparam int unsigned QTR_CYC    = (SCL_QTR_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned QTR_W      = 7;
    localparam logic [QTR_W-1:0] QTR_MAX = QTR_W'(QTR_CYC - 1);
    localparam logic [3:0] LAST_BIT = 4'h8;

    // =====================================================================
    // Engine states
    typedef enum logic [4:0] {
        S_IDLE  = 5'h01,
        S_START = 5'h02,
        S_BYTE  = 5'h04,
        S_STOP  = 5'h08,
        S_WAIT  = 5'h10
    } ismh_state_t;

endpackage

// file: ismh_slave.sv
// Behavioural target device for the two-wire bus
`timescale 1ns/1ps
module ismh_slave (
    // Bus lines
    input  wire logic       scl,
    input  wire logic       sda,
    // Behaviour controls
    input  wire logic       ack_en,
    input  wire logic       slow,
    // Pull-downs and received byte
    output logic            sda_dn,
    output logic            scl_dn,
    output logic [7:0]      rx
);
    int cnt = 0;
    initial {sda_dn, scl_dn, rx} = '0;
    // A start resets the bit count
    always @(negedge sda) if (scl) cnt = 0;
    // Shift on rising clock, MSB first
    always @(posedge scl) if (cnt > 0 && cnt < 9) rx = {rx[6:0], sda};
    // Acknowledge bit follows the eighth bit, released one bit later
    always @(negedge scl) begin
        cnt = (cnt == 9) ? 1 : cnt + 1;
        sda_dn <= (cnt == 9) && ack_en;
    end
    // Slow answer: hold the clock low past the master's release and past
    // the following quarter, so a quarter tick is really held back
    always @(negedge scl) if (slow) begin
        scl_dn = 1'b1;
        #9000 scl_dn = 1'b0;
    end
endmodule

// file: ismh_sync.sv
// Two-flop synchroniser for pin inputs, one stage pair per bit
`timescale 1ns/1ps
module ismh_sync #(
    parameter int unsigned WIDTH = 2
) (
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             arst_n,
    // Asynchronous inputs and their synchronised copies
    input  wire logic [WIDTH-1:0] d_in,
    output logic      [WIDTH-1:0] d_out
);
    import ismh_pkg::*;

    logic [WIDTH-1:0] meta_q;

    // =====================================================================
    // Each bit passes two flops; only the second stage is read outside
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        always_ff @(posedge ref_clk or negedge arst_n) begin
            if (!arst_n) begin
                meta_q[i] <= 1'b1;
                d_out[i]  <= 1'b1;
            end else begin
                meta_q[i] <= d_in[i];
                d_out[i]  <= meta_q[i];
            end
        end
    end
endmodule

// file: ismh_tick.sv
// Quarter-bit tick generator for the serial clock timing
`timescale 1ns/1ps
module ismh_tick (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic arst_n,
    // Control and output pulse
    input  wire logic clr,
    output logic      tick
);
    import ismh_pkg::*;

    logic [QTR_W-1:0] cnt_q;

    // =====================================================================
    // Restarted while idle so every operation begins on a full quarter
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= '0;
            tick  <= 1'b0;
        end else if (clr) begin
            cnt_q <= '0;
            tick  <= 1'b0;
        end else if (cnt_q == QTR_MAX) begin
            cnt_q <= '0;
            tick  <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 1'b1;
            tick  <= 1'b0;
        end
    end
endmodule

// file: ismh_top.sv
// Two-wire bus master engine with software handshake and AHB-Lite slave
//
// Added by the designer: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
module ismh_top (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        arst_n,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic      [31:0] hrdata,
    output logic             hresp,
    // Serial clock pin (open drain)
    input  wire logic        scl_i,
    output logic             scl_o,
    output logic             scl_oe,
    // Serial data pin (open drain)
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe,
    // Interrupt
    output logic             irq
);
    import ismh_pkg::*;

    ismh_state_t      state_q;
    logic [1:0]       ph_q;
    logic [3:0]       bit_q;
    logic [8:0]       shf_q;
    logic             own_q;
    logic             first_q;
    logic             rx_q;
    logic             done_q;
    logic [7:0]       code_q;
    logic             flag_q;
    logic             go_q;
    logic             en_q;
    logic             sta_q;
    logic             sto_q;
    logic             wc_q;
    logic [7:0]       data_q;
    logic [1:0]       pre_q;
    logic [IRQ_W-1:0] irq_stat_q;
    logic [IRQ_W-1:0] irq_mask_q;
    logic [IRQ_W-1:0] irq_ev;
    logic             wr_q;
    logic [7:0]       ofs_q;
    logic             addr_ok;
    logic             in_map;
    logic [31:0]      rd_d;
    logic             wr_ctrl;
    logic             wr_data;
    logic             wr_stat;
    logic             wr_irq;
    logic             wr_mask;
    logic             scl_s;
    logic             sda_s;
    logic             tick;
    logic             tick_clr;
    logic             step;
    logic             launch;
    logic             flag_clr;

    // =====================================================================
    // Pin synchronisers and bit timing
    ismh_sync #(.WIDTH(2)) u_sync (
        .ref_clk (ref_clk),
        .arst_n  (arst_n),
        .d_in    ({scl_i, sda_i}),
        .d_out   ({scl_s, sda_s})
    );

    assign tick_clr = (state_q == S_IDLE) || (state_q == S_WAIT);

    ismh_tick u_tick (
        .ref_clk (ref_clk),
        .arst_n  (arst_n),
        .clr     (tick_clr),
        .tick    (tick)
    );

    // A released clock that a slave still holds low stalls the phase
    assign step = tick && !(!scl_oe && !scl_s);

    // =====================================================================
    // Bus address phase: capture write target, register read data
    assign addr_ok = hsel && htrans[1] && hready;
    assign in_map  = (haddr[31:8] == 24'h00_0000);

    always_comb begin
        rd_d = 32'h0000_0000;
        if (in_map) begin
            case (haddr[7:0])
                CTRL_OFS: begin
                    rd_d[CTRL_FLAG_BIT] = flag_q;
                    rd_d[CTRL_STA_BIT]  = sta_q;
                    rd_d[CTRL_STO_BIT]  = sto_q;
                    rd_d[CTRL_WC_BIT]   = wc_q;
                    rd_d[CTRL_EN_BIT]   = en_q;
                end
                STAT_OFS:     rd_d[7:0] = {code_q[7:3], 1'b0, pre_q};
                DATA_OFS:     rd_d[7:0] = data_q;
                IRQ_STAT_OFS: rd_d[IRQ_W-1:0] = irq_stat_q;
                IRQ_MASK_OFS: rd_d[IRQ_W-1:0] = irq_mask_q;
                default:      rd_d = 32'h0000_0000;
            endcase
        end
    end

    // Zero wait states; unmapped addresses read zero, writes dropped
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_q      <= 1'b0;
            ofs_q     <= 8'h00;
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            wr_q      <= addr_ok && hwrite && in_map;
            ofs_q     <= haddr[7:0];
            hrdata    <= (addr_ok && !hwrite) ? rd_d : 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // Data-phase write strobes
    assign wr_ctrl = wr_q && (ofs_q == CTRL_OFS);
    assign wr_stat = wr_q && (ofs_q == STAT_OFS);
    assign wr_data = wr_q && (ofs_q == DATA_OFS);
    assign wr_irq  = wr_q && (ofs_q == IRQ_STAT_OFS);
    assign wr_mask = wr_q && (ofs_q == IRQ_MASK_OFS);

    // =====================================================================
    // Control bits; a pending request waits until the flag is clear
    assign flag_clr = wr_ctrl && hwdata[CTRL_FLAG_BIT];
    assign launch   = en_q && go_q && !flag_q && tick_clr;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            en_q  <= 1'b0;
            sta_q <= 1'b0;
            sto_q <= 1'b0;
            go_q  <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                en_q  <= hwdata[CTRL_EN_BIT];
                sta_q <= hwdata[CTRL_STA_BIT];
            end
            // Stop request is consumed by hardware once it runs
            if (wr_ctrl) begin
                sto_q <= hwdata[CTRL_STO_BIT];
            end else if (launch && !sta_q && sto_q) begin
                sto_q <= 1'b0;
            end
            // Writes without the flag bit never launch anything
            if (flag_clr && hwdata[CTRL_EN_BIT]) begin
                go_q <= 1'b1;
            end else if (launch || !en_q) begin
                go_q <= 1'b0;
            end
        end
    end

    // Completion flag: a hardware set wins over a software clear
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            flag_q <= 1'b0;
        end else if (done_q) begin
            flag_q <= 1'b1;
        end else if (flag_clr) begin
            flag_q <= 1'b0;
        end
    end

    // Data and prescaler; data writes outside the flag are discarded
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            data_q <= DATA_RST;
            wc_q   <= 1'b0;
            pre_q  <= PRE_RST;
        end else begin
            if (wr_data && flag_q) begin
                data_q <= hwdata[7:0];
                wc_q   <= 1'b0;
            end else if (wr_data) begin
                wc_q   <= 1'b1;
            end
            if (wr_stat) begin
                pre_q <= hwdata[STAT_PRE_W-1:0];
            end
        end
    end

    // =====================================================================
    // Bus engine: four quarter phases per start, bit and stop
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= S_IDLE;
            ph_q    <= 2'd0;
            bit_q   <= 4'h0;
            shf_q   <= 9'h1FF;
            own_q   <= 1'b0;
            first_q <= 1'b0;
            rx_q    <= 1'b1;
            done_q  <= 1'b0;
            code_q  <= ST_NOINFO;
            scl_oe  <= 1'b0;
            sda_oe  <= 1'b0;
        end else if (!en_q) begin
            // Disabled: release both lines and forget the bus
            state_q <= S_IDLE;
            ph_q    <= 2'd0;
            own_q   <= 1'b0;
            done_q  <= 1'b0;
            scl_oe  <= 1'b0;
            sda_oe  <= 1'b0;
        end else begin
            done_q <= 1'b0;
            case (state_q)
                S_IDLE, S_WAIT: begin
                    // Clock stays low here while the flag is up and the bus is owned
                    if (launch) begin
                        ph_q <= 2'd0;
                        if (sta_q) begin
                            state_q <= S_START;
                        end else if (sto_q) begin
                            state_q <= S_STOP;
                        end else if (own_q) begin
                            state_q <= S_BYTE;
                            shf_q   <= {data_q, 1'b1};
                            bit_q   <= 4'h0;
                        end
                    end
                end
                S_START: begin
                    if (step) begin
                        ph_q <= ph_q + 2'd1;
                        case (ph_q)
                            2'd0:    sda_oe <= 1'b0;
                            2'd1:    scl_oe <= 1'b0;
                            2'd2:    sda_oe <= 1'b1;
                            default: begin
                                scl_oe  <= 1'b1;
                                state_q <= S_WAIT;
                                done_q  <= 1'b1;
                                code_q  <= own_q ? ST_RSTART : ST_START;
                                own_q   <= 1'b1;
                                first_q <= 1'b1;
                            end
                        endcase
                    end
                end
                S_BYTE: begin
                    if (step) begin
                        ph_q <= ph_q + 2'd1;
                        case (ph_q)
                            2'd0:    sda_oe <= !shf_q[8];
                            2'd1:    scl_oe <= 1'b0;
                            2'd2:    rx_q   <= sda_s;
                            default: begin
                                scl_oe <= 1'b1;
                                shf_q  <= {shf_q[7:0], 1'b1};
                                bit_q  <= bit_q + 4'h1;
                                // Flag only after the ninth clock samples ack
                                if (bit_q == LAST_BIT) begin
                                    state_q <= S_WAIT;
                                    done_q  <= 1'b1;
                                    first_q <= 1'b0;
                                    if (first_q) begin
                                        code_q <= rx_q ? ST_ANACK : ST_AACK;
                                    end else begin
                                        code_q <= rx_q ? ST_DNACK : ST_DACK;
                                    end
                                end
                            end
                        endcase
                    end
                end
                S_STOP: begin
                    if (step) begin
                        ph_q <= ph_q + 2'd1;
                        case (ph_q)
                            2'd0:    sda_oe <= 1'b1;
                            2'd1:    scl_oe <= 1'b0;
                            2'd2:    sda_oe <= 1'b0;
                            default: begin
                                // No completion event after a stop
                                state_q <= S_IDLE;
                                own_q   <= 1'b0;
                                code_q  <= ST_NOINFO;
                            end
                        endcase
                    end
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end

    // Open-drain outputs only ever pull low
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            scl_o <= 1'b0;
            sda_o <= 1'b0;
        end else begin
            scl_o <= 1'b0;
            sda_o <= 1'b0;
        end
    end

    // =====================================================================
    // Interrupts: sticky, write one to clear, set wins over clear
    assign irq_ev[IRQ_DONE_BIT] = done_q;
    assign irq_ev[IRQ_WC_BIT]   = wr_data && !flag_q;
    assign irq_ev[IRQ_NACK_BIT] = done_q &&
                                  (code_q == ST_ANACK || code_q == ST_DNACK);

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_stat_q <= '0;
            irq_mask_q <= MASK_RST;
            irq        <= 1'b0;
        end else begin
            irq_stat_q <= (irq_stat_q &
                          ~(wr_irq ? hwdata[IRQ_W-1:0] : '0)) | irq_ev;
            if (wr_mask) begin
                irq_mask_q <= hwdata[IRQ_W-1:0];
            end
            irq <= |(irq_stat_q & irq_mask_q);
        end
    end

    // =====================================================================
    // Assertions
    property p_flag_blocks;
        @(posedge ref_clk) disable iff (!arst_n)
        flag_q |-> !(state_q inside {S_START, S_BYTE, S_STOP});
    endproperty
    a_flag_blocks: assert property (p_flag_blocks)
        else $error("bus operation running while flag set");

    property p_w1_clears;
        @(posedge ref_clk) disable iff (!arst_n)
        (flag_clr && !done_q) |=> !flag_q;
    endproperty
    a_w1_clears: assert property (p_w1_clears)
        else $error("flag not cleared by writing one");

    property p_w0_keeps;
        @(posedge ref_clk) disable iff (!arst_n)
        (wr_ctrl && !hwdata[CTRL_FLAG_BIT] && flag_q) |=> flag_q;
    endproperty
    a_w0_keeps: assert property (p_w0_keeps)
        else $error("flag changed by writing zero");

    property p_stop_now;
        @(posedge ref_clk) disable iff (!arst_n)
        (flag_clr && hwdata[CTRL_EN_BIT] && hwdata[CTRL_STO_BIT] &&
         !hwdata[CTRL_STA_BIT] && en_q && !done_q && tick_clr)
        |=> ##1 (state_q == S_STOP);
    endproperty
    a_stop_now: assert property (p_stop_now)
        else $error("stop not started after flag clear");

    property p_stop_silent;
        @(posedge ref_clk) disable iff (!arst_n)
        (state_q == S_STOP) |=> !done_q ##1 !$rose(flag_q);
    endproperty
    a_stop_silent: assert property (p_stop_silent)
        else $error("completion raised after stop");

    property p_done_sets;
        @(posedge ref_clk) disable iff (!arst_n)
        done_q |=> flag_q && $stable(code_q);
    endproperty
    a_done_sets: assert property (p_done_sets)
        else $error("finished operation did not set flag");

    property p_stretch;
        @(posedge ref_clk) disable iff (!arst_n)
        (flag_q && en_q && own_q) |-> scl_oe;
    endproperty
    a_stretch: assert property (p_stretch)
        else $error("clock released while flag set");

    property p_start_code;
        @(posedge ref_clk) disable iff (!arst_n)
        (state_q == S_START && step && ph_q == 2'd3 && !own_q && en_q)
        |=> done_q && (code_q == ST_START) ##1 flag_q;
    endproperty
    a_start_code: assert property (p_start_code)
        else $error("start did not report code 0x08");

    property p_ack_first;
        @(posedge ref_clk) disable iff (!arst_n)
        (done_q && $past(state_q) == S_BYTE) |-> $past(bit_q) == LAST_BIT;
    endproperty
    a_ack_first: assert property (p_ack_first)
        else $error("byte flagged before acknowledge bit");

    property p_collide;
        @(posedge ref_clk) disable iff (!arst_n)
        (wr_data && !flag_q) |=> wc_q && $stable(data_q);
    endproperty
    a_collide: assert property (p_collide)
        else $error("data write without flag not discarded");

    property p_disabled;
        @(posedge ref_clk) disable iff (!arst_n)
        !en_q |=> (state_q == S_IDLE) && !scl_oe && !sda_oe;
    endproperty
    a_disabled: assert property (p_disabled)
        else $error("engine active while disabled");

endmodule

// file: tb_ismh_top.sv
// Self-checking bench of the two-wire master engine
`timescale 1ns/1ps
module tb_ismh_top;
    import ismh_pkg::*;
    logic        ref_clk, arst_n, hsel, hwrite, ack_en, slow;
    logic        hready, hreadyout, hresp, scl_o, scl_oe;
    logic        sda_o, sda_oe, irq, s_dn, c_dn;
    logic [1:0]  htrans;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [7:0]  rx, b, ofs[6];
    logic [31:0] rst[6];
    logic [7:0]  sent[$];
    int          num_errors, cmp_count, st;
    // Open-drain lines with pull-ups
    wire         scl = !(scl_oe || c_dn);
    wire         sda = !(sda_oe || s_dn);
    assign hready = hreadyout;
    ismh_top ismh_top_i (.ref_clk, .arst_n, .hsel, .haddr, .htrans,
        .hwrite, .hsize(3'h2), .hwdata, .hready, .hreadyout, .hrdata,
        .hresp, .scl_i(scl), .scl_o, .scl_oe, .sda_i(sda), .sda_o,
        .sda_oe, .irq);
    ismh_slave ismh_slave_i (.scl, .sda, .ack_en, .slow, .sda_dn(s_dn),
        .scl_dn(c_dn), .rx);
    // Clock
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    // Comparison and verdict
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            num_errors++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Bounded wait for hready at a rising edge
    task automatic rdy();
        int n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (hready !== 1'b1 && n < 20);
        if (hready !== 1'b1) begin
            num_errors++;
            report_and_stop();
        end
    endtask
    // One single AHB-Lite word transfer; read data lands in rd
    task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
        @(posedge ref_clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        rdy();
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        rdy();
        rd = hrdata;
        chk("hresp", 0, hresp);
    endtask
    // Launch an operation, poll the flag, compare the masked status
    task automatic op(logic [7:0] c, int e);
        int n = 0;
        bus(1'b1, CTRL_OFS, {24'h0, c});
        do begin
            bus(1'b0, CTRL_OFS, 0);
            n++;
        end while (rd[CTRL_FLAG_BIT] !== 1'b1 && n < 2000);
        if (rd[CTRL_FLAG_BIT] !== 1'b1) begin
            num_errors++;
            report_and_stop();
        end
        chk("scl_oe", 1, scl_oe);
        bus(1'b0, STAT_OFS, 0);
        chk("status", e, rd & 32'hF8);
    endtask
    // Main sequence
    initial begin
        {arst_n, hsel, hwrite, htrans, haddr, hwdata, ack_en, slow} = '0;
        num_errors = 0;
        cmp_count = 0;
        ofs = '{CTRL_OFS, STAT_OFS, DATA_OFS, IRQ_STAT_OFS, IRQ_MASK_OFS,
            8'h40};
        rst = '{0, 32'hF8, 32'hFF, 0, 0, 0};
        void'($urandom(32'hf28a));
        repeat (10) @(posedge ref_clk);
        arst_n <= 1'b1;
        foreach (ofs[i]) begin
            bus(1'b0, ofs[i], 0);
            chk("reset", rst[i], rd);
        end
        // Prescaler bits stay set so the status mask really matters
        bus(1'b1, STAT_OFS, 32'h3);
        bus(1'b0, STAT_OFS, 0);
        chk("pre", 32'hFB, rd);
        $display("reset values done");
        // Data write with the flag clear is dropped
        bus(1'b1, DATA_OFS, 32'h55);
        bus(1'b0, DATA_OFS, 0);
        chk("data", 32'hFF, rd);
        bus(1'b0, CTRL_OFS, 0);
        chk("wc", 32'h08, rd);
        bus(1'b0, IRQ_STAT_OFS, 0);
        chk("irqwc", 32'h2, rd);
        // Start request without enable is ignored
        bus(1'b1, CTRL_OFS, 32'hA0);
        repeat (400) @(posedge ref_clk);
        bus(1'b0, CTRL_OFS, 0);
        chk("off", 0, rd[CTRL_FLAG_BIT] | scl_oe);
        bus(1'b1, IRQ_STAT_OFS, 32'h7);
        bus(1'b1, IRQ_MASK_OFS, 32'h7);
        $display("collision and disable done");
        ack_en = 1'b1;
        op(8'hA4, ST_START);
        chk("irq", 1, irq);
        // Writing zero to the flag neither clears it nor launches
        bus(1'b1, CTRL_OFS, 32'h24);
        repeat (200) @(posedge ref_clk);
        bus(1'b0, CTRL_OFS, 0);
        chk("flag", 1, rd[CTRL_FLAG_BIT] & scl_oe);
        $display("start done");
        // Address then three bytes, one stretched, one refused
        for (int i = 0; i < 4; i++) begin
            b = $urandom;
            if (i == 0) b[0] = 1'b0;
            ack_en = (i != 3);
            slow = (i == 2);
            bus(1'b1, DATA_OFS, {24'h0, b});
            sent.push_back(b);
            st = (i == 0) ? ST_AACK : ack_en ? ST_DACK : ST_DNACK;
            op(8'h84, st);
            chk("rx", sent.pop_front(), rx);
        end
        ack_en = 1'b1;
        slow = 1'b0;
        // Done from every operation, nack from the refused byte
        bus(1'b0, IRQ_STAT_OFS, 0);
        chk("irqst", 32'h5, rd);
        op(8'hA4, ST_RSTART);
        $display("bytes done");
        // Stop: begins at once, no flag, no event
        bus(1'b1, IRQ_STAT_OFS, 32'h7);
        bus(1'b1, CTRL_OFS, 32'h94);
        repeat (100) @(posedge ref_clk);
        chk("stop", 1, sda_oe);
        repeat (500) @(posedge ref_clk);
        bus(1'b0, IRQ_STAT_OFS, 0);
        chk("irqst", 0, rd);
        bus(1'b0, CTRL_OFS, 0);
        chk("flag", 0, rd[CTRL_FLAG_BIT] | scl_oe);
        chk("sda", 1, sda);
        bus(1'b0, STAT_OFS, 0);
        chk("status", 32'hF8, rd & 32'hF8);
        chk("irq", 0, irq);
        chk("pins", 0, {scl_o, sda_o});
        $display("stop done");
        report_and_stop();
    end
endmodule
